// ==== design/rtex_unit.v ====
// Purpose: reset, trace and exception vector sequencing for the cpu
// Assumes: all inputs synchronous to CLK; sequencer holds requests as levels
// Notes: one exception is issued per instruction boundary
`timescale 1ns/1ps
`default_nettype none
`include "rtex_defs.vh"
module rtex_unit (
  input wire CLK,
  input wire RST_N,
  input wire POR_PIN_N,
  input wire MAN_PIN_N,
  input wire MANUAL_RESET_INPUT_ENABLE,
  input wire WDT_OVF,
  input wire WDT_TYPE_MANUAL,
  input wire INSN_DONE,
  input wire INSN_IS_RTE,
  input wire INSN_FLAG_WR,
  input wire FLAG_WR_I,
  input wire FLAG_WR_UI,
  input wire FLAG_WR_T,
  input wire [2:0] FLAG_WR_MASK,
  input wire MODE_WR,
  input wire [1:0] MODE_WDATA,
  input wire IRQ_REQ,
  input wire [6:0] IRQ_VEC,
  input wire TRAP_REQ,
  input wire [1:0] TRAP_NUM,
  input wire MSTP_WR,
  input wire [1:0] MSTP_SEL,
  input wire [7:0] MSTP_WDATA,
  output reg CPU_HALT,
  output reg PERIPH_RST,
  output reg BUSIO_RST,
  output reg PORT_REVERT,
  output reg LAST_RST_MANUAL,
  output reg EXC_TAKE,
  output reg EXC_TRACE,
  output reg [6:0] EXC_VEC,
  output reg [15:0] EXC_ADDR,
  output reg SAVED_T,
  output reg [1:0] INT_MODE,
  output reg CCR_I,
  output reg CCR_UI,
  output reg EXR_T,
  output reg [2:0] EXR_MASK,
  output reg [7:0] MSTP_A,
  output reg [7:0] MSTP_B,
  output reg [7:0] MSTP_C
);
  localparam [2:0] ST_RST = 3'b001;
  localparam [2:0] ST_VEC = 3'b010;
  localparam [2:0] ST_RUN = 3'b100;

  reg [2:0] st_ff;
  reg [2:0] nxt_st;
  reg lockout_ff;
  wire rst_active;
  wire rst_manual;

  // lower 16 address bits of a vector entry, four bytes each
  function [15:0] vec_addr;
    input [6:0] vec;
    begin
      vec_addr = {7'h00, vec, 2'b00}; // [RULE1]
    end
  endfunction

  rtex_rst_src u_src (
    .clk(CLK),
    .rst_n(RST_N),
    .por_pin_n(POR_PIN_N),
    .man_pin_n(MAN_PIN_N),
    .man_en(MANUAL_RESET_INPUT_ENABLE),
    .wdt_ovf(WDT_OVF),
    .wdt_type_manual(WDT_TYPE_MANUAL),
    .rst_active_ff(rst_active),
    .rst_manual_ff(rst_manual)
  );

  always @* begin
    nxt_st = st_ff;
    case (st_ff)
      ST_RST: begin
        if (!rst_active) begin
          nxt_st = ST_VEC;
        end
      end
      ST_VEC: begin
        nxt_st = ST_RUN;
      end
      ST_RUN: begin
        nxt_st = ST_RUN;
      end
      default: begin
        nxt_st = ST_RST;
      end
    endcase
    if (rst_active) begin
      nxt_st = ST_RST; // [RULE3] [RULE21]
    end
  end

  // boundary decisions, highest first
  wire run = st_ff[2] & ~rst_active;
  wire at_bnd = run & INSN_DONE;
  wire trace_go = at_bnd & EXR_T & (INT_MODE == `RTEX_MODE2)
    & ~INSN_IS_RTE; // [RULE14] [RULE15] [RULE17]
  // lockout covers first instruction; flag writes hide the boundary
  wire irq_ok = ~lockout_ff & ~INSN_FLAG_WR; // [RULE12] [RULE22]
  wire irq_go = at_bnd & IRQ_REQ & irq_ok & ~trace_go; // [RULE21]
  wire trap_go = at_bnd & TRAP_REQ & ~trace_go & ~irq_go; // [RULE21]
  wire any_go = trace_go | irq_go | trap_go;
  wire t_now = INSN_FLAG_WR ? FLAG_WR_T : EXR_T;

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_ff <= ST_RST;
      lockout_ff <= 1'b1;
      CPU_HALT <= 1'b1;
      PERIPH_RST <= 1'b1;
      BUSIO_RST <= 1'b1;
      PORT_REVERT <= 1'b0;
      LAST_RST_MANUAL <= 1'b0;
      EXC_TAKE <= 1'b0;
      EXC_TRACE <= 1'b0;
      EXC_VEC <= `RTEX_VEC_POR;
      EXC_ADDR <= 16'h0000;
      SAVED_T <= 1'b0;
      INT_MODE <= `RTEX_MODE0;
      CCR_I <= 1'b1;
      CCR_UI <= 1'b0;
      EXR_T <= 1'b0;
      EXR_MASK <= `RTEX_MASK_RST;
      MSTP_A <= `RTEX_MSTPA_RST;
      MSTP_B <= `RTEX_MSTPB_RST;
      MSTP_C <= `RTEX_MSTPC_RST;
    end else begin
      st_ff <= nxt_st;
      EXC_TAKE <= 1'b0;
      EXC_TRACE <= 1'b0;
      if (rst_active) begin
        CPU_HALT <= 1'b1; // [RULE3]
        PERIPH_RST <= 1'b1; // [RULE5]
        // bus controller and ports keep state on a manual reset
        BUSIO_RST <= ~rst_manual; // [RULE5]
        PORT_REVERT <= rst_manual; // [RULE6]
        LAST_RST_MANUAL <= rst_manual;
        lockout_ff <= 1'b1; // [RULE12]
        INT_MODE <= `RTEX_MODE0; // [RULE9]
        EXR_T <= 1'b0; // [RULE10]
        CCR_I <= 1'b1; // [RULE10]
        CCR_UI <= 1'b0;
        EXR_MASK <= `RTEX_MASK_RST; // [RULE10]
        SAVED_T <= 1'b0;
        // values stand at release; every module but dma and transfer stops
        MSTP_A <= `RTEX_MSTPA_RST; // [RULE13]
        MSTP_B <= `RTEX_MSTPB_RST; // [RULE13]
        MSTP_C <= `RTEX_MSTPC_RST; // [RULE13]
      end else if (st_ff[1]) begin
        CPU_HALT <= 1'b0;
        PERIPH_RST <= 1'b0;
        BUSIO_RST <= 1'b0;
        PORT_REVERT <= 1'b0;
        EXC_TAKE <= 1'b1; // [RULE11]
        EXC_VEC <= LAST_RST_MANUAL ? `RTEX_VEC_MAN : `RTEX_VEC_POR; // [RULE2]
        EXC_ADDR <= vec_addr(LAST_RST_MANUAL ? `RTEX_VEC_MAN
          : `RTEX_VEC_POR); // [RULE11]
      end else if (run) begin
        if (MODE_WR) begin
          INT_MODE <= MODE_WDATA;
        end
        if (MSTP_WR) begin
          case (MSTP_SEL)
            `RTEX_MSTP_SEL_A: MSTP_A <= MSTP_WDATA;
            `RTEX_MSTP_SEL_B: MSTP_B <= MSTP_WDATA;
            `RTEX_MSTP_SEL_C: MSTP_C <= MSTP_WDATA;
            default: MSTP_A <= MSTP_A;
          endcase
        end
        if (INSN_DONE) begin
          lockout_ff <= 1'b0;
        end
        // a flag write lands first; an exception taken now overrides its I bit, and its T bit in mode 2
        if (at_bnd & INSN_FLAG_WR) begin
          CCR_I <= FLAG_WR_I;
          CCR_UI <= FLAG_WR_UI;
          EXR_T <= FLAG_WR_T; // [RULE19]
          EXR_MASK <= FLAG_WR_MASK;
        end
        if (any_go) begin
          EXC_TAKE <= 1'b1;
          // stacked copy keeps the flag so return resumes tracing
          SAVED_T <= t_now; // [RULE19]
          CCR_I <= 1'b1; // [RULE16]
          if (INT_MODE == `RTEX_MODE2) begin
            EXR_T <= 1'b0; // [RULE16]
          end
        end
        if (trace_go) begin
          EXC_TRACE <= 1'b1; // [RULE15]
          EXC_VEC <= `RTEX_VEC_TRACE; // [RULE2]
          EXC_ADDR <= vec_addr(`RTEX_VEC_TRACE);
        end else if (irq_go) begin
          // trace handler does not block interrupts
          EXC_VEC <= IRQ_VEC; // [RULE18] [RULE2]
          EXC_ADDR <= vec_addr(IRQ_VEC);
        end else if (trap_go) begin
          EXC_VEC <= `RTEX_VEC_TRAP0 + {5'h00, TRAP_NUM}; // [RULE2]
          EXC_ADDR <= vec_addr(`RTEX_VEC_TRAP0 + {5'h00, TRAP_NUM});
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== design/rtex_defs.vh ====
// Purpose: shared constants of the reset and trace exception unit
// Assumes: included by bare name from the design files
// Notes: definitions only
// Contract
// [RULE1] advanced layout only: each vector four bytes at four times number
// [RULE2] vec: por 0, man 1, trace 5, nmi 7, trap 8-11, ext 16-23, int 24-127
// [RULE3] reset is highest; while a reset pin is low all processing halts
// [RULE4] outside source holds power-on pin low at least 20 ms
// [RULE5] power-on resets all; manual keeps bus controller and i/o ports
// [RULE6] after manual reset peripheral pins revert to general ports
// [RULE7] watchdog overflow resets the device, as power-on or manual type
// [RULE8] manual pin counts only while its input enable bit is one
// [RULE9] after any reset interrupt control mode 0 is selected
// [RULE10] on release: state initialised, trace flag 0, mask flags 1
// [RULE11] then the reset vector of the active type is loaded and run
// [RULE12] all interrupts blocked until the first instruction has executed
// [RULE13] on release module stop registers are 3F, FF, FF
// [RULE14] trace only in mode 2, never in mode 0
// [RULE15] trace flag one gives a trace after each instruction, unmasked
// [RULE16] after trace: mask flag 1, trace flag 0, user flag and level kept
// [RULE17] no trace exception after the exception return instruction
// [RULE18] interrupts are accepted inside the trace handler
// [RULE19] stacked trace flag stays one so return resumes trace
// [RULE20] outside system drives the scan test reset low at power-on
// [RULE21] priority: reset, trace, interrupt, trap instruction
// [RULE22] no interrupt after a flag write instruction or reset handling
`ifndef RTEX_DEFS_VH
`define RTEX_DEFS_VH
`define RTEX_VEC_POR 7'h00
`define RTEX_VEC_MAN 7'h01
`define RTEX_VEC_TRACE 7'h05
`define RTEX_VEC_NMI 7'h07
`define RTEX_VEC_TRAP0 7'h08
`define RTEX_VEC_EXT0 7'h10
`define RTEX_VEC_INT0 7'h18
`define RTEX_VEC_LAST 7'h7F
`define RTEX_MODE0 2'h0
`define RTEX_MODE2 2'h2
`define RTEX_MSTPA_RST 8'h3F
`define RTEX_MSTPB_RST 8'hFF
`define RTEX_MSTPC_RST 8'hFF
`define RTEX_MASK_RST 3'h7
`define RTEX_MSTP_SEL_A 2'h0
`define RTEX_MSTP_SEL_B 2'h1
`define RTEX_MSTP_SEL_C 2'h2
`define RTEX_POR_HOLD_MS 20
`define RTEX_WDT_HOLD 4'h8
`endif

// ==== design/rtex_rst_src.v ====
// Purpose: turns reset pins and watchdog overflow into a reset level and type
// Assumes: pins are synchronous to clk
// Notes: watchdog reset is stretched so the sequencer sees a full reset
`timescale 1ns/1ps
`default_nettype none
`include "rtex_defs.vh"
module rtex_rst_src (
  input wire clk,
  input wire rst_n,
  input wire por_pin_n,
  input wire man_pin_n,
  input wire man_en,
  input wire wdt_ovf,
  input wire wdt_type_manual,
  output reg rst_active_ff,
  output reg rst_manual_ff
);
  reg [3:0] wdt_cnt_ff;
  reg wdt_man_ff;
  wire por_req = ~por_pin_n;
  // manual pin ignored unless enabled, and power-on pin wins
  wire man_req = ~man_pin_n & man_en & por_pin_n; // [RULE8] [RULE5]
  wire wdt_busy = (wdt_cnt_ff != 4'h0);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdt_cnt_ff <= 4'h0;
      wdt_man_ff <= 1'b0;
      rst_active_ff <= 1'b1;
      rst_manual_ff <= 1'b0;
    end else begin
      if (wdt_ovf) begin
        wdt_cnt_ff <= `RTEX_WDT_HOLD; // [RULE7]
        wdt_man_ff <= wdt_type_manual; // [RULE7]
      end else if (wdt_busy) begin
        wdt_cnt_ff <= wdt_cnt_ff - 4'h1;
      end
      rst_active_ff <= por_req | man_req | wdt_ovf | wdt_busy; // [RULE3]
      if (por_req) begin
        rst_manual_ff <= 1'b0; // [RULE5]
      end else if (wdt_ovf) begin
        rst_manual_ff <= wdt_type_manual;
      end else if (wdt_busy) begin
        rst_manual_ff <= wdt_man_ff;
      end else if (man_req) begin
        rst_manual_ff <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== testbench/rtex_unit_props.sv ====
// Purpose: port checker for rtex_unit
// Assumes: one clock domain
// Notes: bound after the module
`timescale 1ns/1ps
`default_nettype none
module rtex_props (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic POR_PIN_N,
  input wire logic MAN_PIN_N,
  input wire logic INSN_DONE,
  input wire logic MANUAL_RESET_INPUT_ENABLE,
  input wire logic INSN_IS_RTE,
  input wire logic INSN_FLAG_WR,
  input wire logic CPU_HALT,
  input wire logic LAST_RST_MANUAL,
  input wire logic EXC_TAKE,
  input wire logic EXC_TRACE,
  input wire logic EXR_T,
  input wire logic CCR_I,
  input wire logic [15:0] EXC_ADDR,
  input wire logic [6:0] EXC_VEC,
  input wire logic [1:0] INT_MODE,
  input wire logic [7:0] MSTP_A,
  input wire logic [7:0] MSTP_B,
  input wire logic [7:0] MSTP_C
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic lock_ff;
  // lockout lasts up to the first boundary after any reset
  always @(posedge CLK or negedge RST_N)
    if (!RST_N) lock_ff <= 1'b1;
    else if (CPU_HALT) lock_ff <= 1'b1;
    else if (INSN_DONE) lock_ff <= 1'b0;
  property p_adr;
    EXC_TAKE |-> EXC_ADDR == {7'h00, EXC_VEC, 2'h0};
  endproperty
  a_adr: assert property (p_adr) else $error("bad address");
  // pin is registered in the source, then again at the outputs
  property p_hlt;
    !POR_PIN_N |-> ##2 CPU_HALT;
  endproperty
  a_hlt: assert property (p_hlt) else $error("no halt");
  property p_man;
    POR_PIN_N && !MAN_PIN_N && MANUAL_RESET_INPUT_ENABLE |-> ##2 CPU_HALT;
  endproperty
  a_man: assert property (p_man) else $error("no manual");
  property p_rst;
    $fell(CPU_HALT) |-> EXC_TAKE && EXC_VEC == {6'h00, LAST_RST_MANUAL}
      && INT_MODE == 2'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset");
  property p_flg;
    $fell(CPU_HALT) |-> CCR_I && !EXR_T;
  endproperty
  a_flg: assert property (p_flg) else $error("bad reset flags");
  property p_msr;
    $fell(CPU_HALT) |-> MSTP_A == 8'h3F && MSTP_B == 8'hFF
      && MSTP_C == 8'hFF;
  endproperty
  a_msr: assert property (p_msr) else $error("bad module stop");
  property p_trc;
    INSN_DONE && !CPU_HALT && EXR_T && INT_MODE == 2'h2 && !INSN_IS_RTE
      |=> EXC_TRACE;
  endproperty
  a_trc: assert property (p_trc) else $error("no trace");
  property p_trv;
    EXC_TRACE |-> EXC_VEC == 7'h05 && !EXR_T && CCR_I;
  endproperty
  a_trv: assert property (p_trv) else $error("bad trace");
  property p_tm0;
    EXC_TRACE |-> $past(INT_MODE) == 2'h2;
  endproperty
  a_tm0: assert property (p_tm0) else $error("trace in mode 0");
  property p_rte;
    INSN_DONE && INSN_IS_RTE |=> !EXC_TRACE;
  endproperty
  a_rte: assert property (p_rte) else $error("trace on rte");
  property p_lck;
    INSN_DONE && !CPU_HALT && (lock_ff || INSN_FLAG_WR) |=> !EXC_TAKE
      || EXC_TRACE || EXC_VEC inside {[7'h08:7'h0B]};
  endproperty
  a_lck: assert property (p_lck) else $error("irq in lock");
  c_trc: cover property (EXC_TRACE);
  c_irq: cover property (EXC_TAKE && EXC_VEC > 7'h0F);
  c_man: cover property (!MAN_PIN_N && MANUAL_RESET_INPUT_ENABLE);
endmodule
bind rtex_unit rtex_props rtex_props_i (
  .CLK(CLK),
  .RST_N(RST_N),
  .POR_PIN_N(POR_PIN_N),
  .MAN_PIN_N(MAN_PIN_N),
  .INSN_DONE(INSN_DONE),
  .MANUAL_RESET_INPUT_ENABLE(MANUAL_RESET_INPUT_ENABLE),
  .INSN_IS_RTE(INSN_IS_RTE),
  .INSN_FLAG_WR(INSN_FLAG_WR),
  .CPU_HALT(CPU_HALT),
  .LAST_RST_MANUAL(LAST_RST_MANUAL),
  .EXC_TAKE(EXC_TAKE),
  .EXC_TRACE(EXC_TRACE),
  .EXR_T(EXR_T),
  .CCR_I(CCR_I),
  .EXC_ADDR(EXC_ADDR),
  .EXC_VEC(EXC_VEC),
  .INT_MODE(INT_MODE),
  .MSTP_A(MSTP_A),
  .MSTP_B(MSTP_B),
  .MSTP_C(MSTP_C)
);
`default_nettype wire

// ==== testbench/rtex_seq_model.sv ====
// Purpose: reset pin and sequencer stand-in
// Assumes: go sampled on the rising edge
// Notes: answers after 0 to 2 idle cycles
`timescale 1ns/1ps
`default_nettype none
module rtex_seq_model (
  input wire logic clk,
  input wire logic go,
  output logic por_n,
  output logic done
);
  // scan test reset of the far side, low through power-on
  logic scan_rst_n;
  initial begin
    {por_n, scan_rst_n, done} = 3'h0;
    // far shorter than 20 ms to keep the run short
    repeat (20) @(posedge clk);
    #2 {por_n, scan_rst_n} = 2'h3;
    forever begin
      @(posedge clk);
      if (go === 1'b1) begin
        repeat ($urandom % 3) @(posedge clk);
        #2 done = 1'b1;
        @(posedge clk) #2 done = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== testbench/test_rtex_unit.sv ====
// Purpose: self-checking bench for rtex_unit
// Assumes: inputs change 2 ns after the edge
// Notes: vectors checked off a queue
`timescale 1ns/1ps
`default_nettype none
module test_rtex_unit;
  logic clk = 1'b0, rst_n = 1'b0, por = 1'b1, man = 1'b1, men = 1'b0;
  logic wdt = 1'b0, wm = 1'b0, go = 1'b0, exception_return_op = 1'b0, fwr = 1'b0;
  logic wt = 1'b0, wui = 1'b0, mwr = 1'b0, irq = 1'b0, trap = 1'b0;
  logic wi = 1'b0, sw = 1'b0;
  logic [1:0] md = 2'h0, tn = 2'h0, ss = 2'h0;
  logic [2:0] mw = 3'h0;
  logic [6:0] iv = 7'h10, e;
  logic [7:0] sd = 8'h00;
  logic [6:0] q [$];
  wire pm, dn, hlt, tk, trc, bio, prv, lm, st, ci, cui, et, prs;
  wire [15:0] adr;
  wire [1:0] mode;
  wire [2:0] msk;
  wire [6:0] vec;
  wire [7:0] ma, mb, mc;
  int err_total = 0, total_checks = 0;
  always #20 clk = ~clk;
  rtex_seq_model rtex_seq_model_i (.clk(clk), .go(go), .por_n(pm),
    .done(dn));
  rtex_unit rtex_unit_i (.CLK(clk), .RST_N(rst_n), .POR_PIN_N(pm & por),
    .MAN_PIN_N(man), .MANUAL_RESET_INPUT_ENABLE(men), .WDT_OVF(wdt),
    .WDT_TYPE_MANUAL(wm), .INSN_DONE(dn), .INSN_IS_RTE(exception_return_op),
    .INSN_FLAG_WR(fwr), .FLAG_WR_I(wi), .FLAG_WR_UI(wui), .FLAG_WR_T(wt),
    .FLAG_WR_MASK(mw), .MODE_WR(mwr), .MODE_WDATA(md), .IRQ_REQ(irq),
    .IRQ_VEC(iv), .TRAP_REQ(trap), .TRAP_NUM(tn), .MSTP_WR(sw),
    .MSTP_SEL(ss), .MSTP_WDATA(sd), .CPU_HALT(hlt), .PERIPH_RST(prs),
    .BUSIO_RST(bio), .PORT_REVERT(prv), .LAST_RST_MANUAL(lm),
    .EXC_TAKE(tk), .EXC_TRACE(trc), .EXC_VEC(vec), .EXC_ADDR(adr),
    .SAVED_T(st), .INT_MODE(mode), .CCR_I(ci), .CCR_UI(cui), .EXR_T(et),
    .EXR_MASK(msk), .MSTP_A(ma), .MSTP_B(mb), .MSTP_C(mc));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // done is looked at on the edge that the design samples it
  task automatic step;
    int n;
    n = 0;
    go = 1'b1;
    @(posedge clk) #2 go = 1'b0;
    do @(posedge clk); while (dn !== 1'b1 && ++n < 9);
    #2 {exception_return_op, fwr, irq, trap} = 4'h0;
    @(posedge clk) #2;
  endtask
  task automatic run;
    int n;
    for (n = 0; n < 40 && hlt !== 1'b0; n++) @(posedge clk) #2;
    repeat (2) @(posedge clk) #2;
  endtask
  task automatic give_verdict;
    if (err_total == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk) begin
    #1;
    if (tk === 1'b1) begin
      if (q.size() == 0) chk(adr, 16'hFFFF);
      else begin
        e = q.pop_front();
        chk(adr, {7'h00, e, 2'h0});
        chk({9'h000, vec}, {9'h000, e});
        chk({15'h0000, trc}, {15'h0000, e == 7'h05});
      end
    end
  end
  initial begin
    #100000;
    err_total++;
    give_verdict;
  end
  initial begin
    void'($urandom(32'hCF8F9D29));
    q.push_back(7'h00);
    repeat (12) @(posedge clk);
    #2 rst_n = 1'b1;
    run;
    chk({3'h0, prs, mode, ci, et, ma}, 16'h023F);
    chk({mb, mc}, 16'hFFFF);
    // second write goes to the unused select and must be dropped
    sd = 8'($urandom);
    {sw, ss} = 3'h5;
    @(posedge clk) #2 ss = 2'h3;
    sd = ~sd;
    @(posedge clk) #2 sw = 1'b0;
    chk({ma, mb}, {8'h3F, ~sd});
    chk({8'h00, mc}, 16'h00FF);
    iv = 7'h10 + 7'($urandom % 112);
    irq = 1'b1;
    step;
    irq = 1'b1;
    q.push_back(iv);
    step;
    {mwr, md} = 3'h6;
    @(posedge clk) #2 mwr = 1'b0;
    mw = 3'($urandom);
    {irq, fwr, wt, wui} = 4'hF;
    step;
    chk({15'h0000, ci}, {15'h0000, wi});
    q.push_back(7'h05);
    irq = 1'b1;
    step;
    chk({12'h000, cui, et, ci, st}, 16'h000B);
    chk({13'h0000, msk}, {13'h0000, mw});
    irq = 1'b1;
    q.push_back(iv);
    step;
    {exception_return_op, fwr, wt, wi} = 4'hF;
    step;
    exception_return_op = 1'b1;
    step;
    q.push_back(7'h05);
    trap = 1'b1;
    step;
    tn = 2'($urandom);
    q.push_back(7'h08 + {5'h00, tn});
    trap = 1'b1;
    step;
    {mwr, md} = 3'h4;
    @(posedge clk) #2 mwr = 1'b0;
    {fwr, wt} = 2'h3;
    step;
    step;
    man = 1'b0;
    repeat (3) @(posedge clk) #2;
    chk({15'h0000, hlt}, 16'h0000);
    men = 1'b1;
    repeat (2) @(posedge clk) #2;
    chk({12'h000, hlt, bio, prv, prs}, 16'h000B);
    q.push_back(7'h01);
    man = 1'b1;
    run;
    chk({15'h0000, lm}, 16'h0001);
    wm = 1'($urandom);
    q.push_back({6'h00, wm});
    wdt = 1'b1;
    @(posedge clk) #2 wdt = 1'b0;
    @(posedge clk) #2;
    chk({15'h0000, hlt}, 16'h0001);
    run;
    chk({15'h0000, lm}, {15'h0000, wm});
    {por, man} = 2'h0;
    repeat (2) @(posedge clk) #2;
    chk({12'h000, hlt, bio, prv, prs}, 16'h000D);
    q.push_back(7'h00);
    {por, man} = 2'h3;
    run;
    chk({ma, mb}, 16'h3FFF);
    chk(16'(q.size()), 16'h0000);
    give_verdict;
  end
endmodule
`default_nettype wire
